// *** core/ppge_core.sv ***
/*
  Proximity pairing, down/left offset correction, gain compensation,
  sleep after interrupt and gesture entry decision.
  Assumes register requests, diode samples and sequencer events all come
  from logic on ref_clk, so no synchronisers are needed.
*/
// Function
// - Up and right diodes form one pair, down and left the other pair.
// - Eight bit offset corrects crosstalk on the down/left pair sum.
// - Offset is sign and magnitude: bit 7 sign, bits 6:0 magnitude.
// - Gain compensation doubles proximity signal, 127 full scale becomes 255.
// - With sleep enabled, interrupt asserted at decision point enters low power unless the host clears it in that same cycle.
// - Low power ends only when host clears the pending interrupt.
// - Mask bits 3..0 disable up, down, left, right diodes when set.
// - Proximity result compared against gesture entry threshold to start gesture.
// - One result meeting threshold suffices, no persistence count applied.
// - Proximity result is unsigned eight bits, readable at its own address.
`timescale 1ns/100ps
module ppge_core
  import ppge_pkg::*;
#(
  parameter int RES_W = DATA_W
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire ppge_reg_req_s     reg_req,
  output logic [DATA_W-1:0]      rd_data_r,
  input  wire ppge_diodes_s      diodes,
  input  wire logic              irq_asserted,
  input  wire logic              sleep_decision,
  input  wire logic              irq_clear,
  output logic [RES_W-1:0]       proximity_result_r,
  output logic                   result_valid_r,
  output logic                   gesture_start_r,
  output logic                   low_power_r
);

  // Elaboration checks on what the datapath can serve
  if (RES_W != DATA_W) begin : g_res_w_check
    $error("ppge_core supports only RES_W equal to DATA_W");
  end
  if (DATA_W != 8) begin : g_data_w_check
    $error("ppge_core datapath is built for eight bit samples");
  end

  logic [DATA_W-1:0] down_left_offset_r;
  logic [DATA_W-1:0] photodiode_selection_r;
  logic [DATA_W-1:0] gesture_entry_level_r;
  ppge_sleep_e       sleep_state_r;
  ppge_sleep_e       sleep_state_nxt;

  logic              mask_up_diode;
  logic              mask_down_diode;
  logic              mask_left_diode;
  logic              mask_right_diode;
  logic              pair_gain_comp;
  logic              sleep_after_irq;

  // Diodes indexed by their mask bit position
  localparam int     DIODE_N = 4;
  logic [DATA_W-1:0] diode_raw  [DIODE_N];
  logic [DIODE_N-1:0] diode_mask;
  logic [9:0]        diode_val  [DIODE_N];

  logic [9:0]        pair_ur;
  logic [10:0]       pair_dl_raw;
  logic [10:0]       dl_magnitude;
  logic [10:0]       pair_dl_sum;
  logic [9:0]        pair_dl;
  logic [10:0]       pair_total;
  logic [10:0]       scaled;
  logic [RES_W-1:0]  proximity_nxt;

  function automatic logic [9:0] masked_diode(input logic [DATA_W-1:0] value, input logic mask);
    masked_diode = mask ? 10'h000 : {2'b00, value};
  endfunction : masked_diode

  function automatic logic addr_hit(input ppge_reg_req_s req, input logic [7:0] addr);
    addr_hit = (req.addr == addr);
  endfunction : addr_hit

  assign mask_up_diode    = photodiode_selection_r[MASK_UP_BIT];
  assign mask_down_diode  = photodiode_selection_r[MASK_DOWN_BIT];
  assign mask_left_diode  = photodiode_selection_r[MASK_LEFT_BIT];
  assign mask_right_diode = photodiode_selection_r[MASK_RIGHT_BIT];
  assign pair_gain_comp   = photodiode_selection_r[PAIR_GAIN_COMP_BIT];
  assign sleep_after_irq  = photodiode_selection_r[SLEEP_AFTER_IRQ_BIT];

  // Masked diode values
  assign diode_raw[MASK_UP_BIT]    = diodes.up;
  assign diode_raw[MASK_DOWN_BIT]  = diodes.down;
  assign diode_raw[MASK_LEFT_BIT]  = diodes.left;
  assign diode_raw[MASK_RIGHT_BIT] = diodes.right;
  assign diode_mask = {mask_up_diode, mask_down_diode, mask_left_diode, mask_right_diode};

  for (genvar g = 0; g < DIODE_N; g++) begin : g_diode_mask
    assign diode_val[g] = masked_diode(diode_raw[g], diode_mask[g]);
  end

  // Pair sums
  always_comb begin
    pair_ur = diode_val[MASK_UP_BIT] + diode_val[MASK_RIGHT_BIT];
    pair_dl_raw = {1'b0, diode_val[MASK_DOWN_BIT]}
                + {1'b0, diode_val[MASK_LEFT_BIT]};
  end

  // Signed offset correction on the down/left pair, clamped to the pair range
  always_comb begin
    dl_magnitude = {4'h0, down_left_offset_r[OFFSET_SIGN_BIT-1:0]};
    if (down_left_offset_r[OFFSET_SIGN_BIT]) begin
      pair_dl_sum = pair_dl_raw + dl_magnitude;
    end else if (pair_dl_raw > dl_magnitude) begin
      pair_dl_sum = pair_dl_raw - dl_magnitude;
    end else begin
      pair_dl_sum = 11'h000;
    end
    if (pair_dl_sum > {1'b0, PAIR_MAX}) begin
      pair_dl = PAIR_MAX;
    end else begin
      pair_dl = pair_dl_sum[9:0];
    end
  end

  // Combine pairs, half scale per pair, optional gain of two
  always_comb begin
    pair_total = {1'b0, pair_ur} + {1'b0, pair_dl};
    if (pair_gain_comp) begin
      scaled = {1'b0, pair_total[10:1]};
    end else begin
      scaled = {2'b00, pair_total[10:2]};
    end
    if (scaled > {3'b000, RESULT_MAX}) begin
      proximity_nxt = RESULT_MAX;
    end else begin
      proximity_nxt = scaled[RES_W-1:0];
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      down_left_offset_r     <= DL_OFFSET_RST;
      photodiode_selection_r <= PD_SELECT_RST;
      gesture_entry_level_r  <= GEST_ENTRY_RST;
    end else if (reg_req.wr) begin
      if (addr_hit(reg_req, DL_OFFSET_ADDR)) begin
        down_left_offset_r <= reg_req.wdata;
      end
      if (addr_hit(reg_req, PD_SELECT_ADDR)) begin
        photodiode_selection_r <= reg_req.wdata & PD_SELECT_WMASK;
      end
      if (addr_hit(reg_req, GEST_ENTRY_ADDR)) begin
        gesture_entry_level_r <= reg_req.wdata;
      end
    end
  end

  // Read data
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_r <= UNMAPPED_READ;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        PROX_RESULT_ADDR: rd_data_r <= proximity_result_r;
        DL_OFFSET_ADDR:   rd_data_r <= down_left_offset_r;
        PD_SELECT_ADDR:   rd_data_r <= photodiode_selection_r;
        GEST_ENTRY_ADDR:  rd_data_r <= gesture_entry_level_r;
        default:          rd_data_r <= UNMAPPED_READ;
      endcase
    end
  end

  // Proximity result capture
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      proximity_result_r <= PROX_RESULT_RST;
      result_valid_r     <= 1'b0;
    end else begin
      result_valid_r <= diodes.valid;
      if (diodes.valid) begin
        proximity_result_r <= proximity_nxt;
      end
    end
  end

  // Gesture entry decision on every single new result
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gesture_start_r <= 1'b0;
    end else begin
      gesture_start_r <= diodes.valid && (proximity_nxt >= gesture_entry_level_r);
    end
  end

  // Sleep after interrupt
  always_comb begin
    sleep_state_nxt = sleep_state_r;
    case (sleep_state_r)
      PPGE_ACTIVE: begin
        if (sleep_after_irq && irq_asserted && sleep_decision && !irq_clear) begin
          sleep_state_nxt = PPGE_LOW_POWER;
        end
      end
      PPGE_LOW_POWER: begin
        if (irq_clear) begin
          sleep_state_nxt = PPGE_ACTIVE;
        end
      end
      default: sleep_state_nxt = PPGE_ACTIVE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_state_r <= PPGE_ACTIVE;
      low_power_r   <= 1'b0;
    end else begin
      sleep_state_r <= sleep_state_nxt;
      low_power_r   <= (sleep_state_nxt == PPGE_LOW_POWER);
    end
  end

endmodule : ppge_core

// *** core/ppge_pkg.sv ***
/*
  Package for the proximity pairing and gesture entry block: register map,
  field positions, reset values, carrier structs and the sleep state enum.
  Assumes a register access port driven by the serial slave on ref_clk.
*/
package ppge_pkg;

  localparam int          DATA_W            = 8;
  localparam int          ADDR_W            = 8;

  // Register byte addresses
  localparam logic [7:0]  PROX_RESULT_ADDR  = 8'h9c;
  localparam logic [7:0]  DL_OFFSET_ADDR    = 8'h9e;
  localparam logic [7:0]  PD_SELECT_ADDR    = 8'h9f;
  localparam logic [7:0]  GEST_ENTRY_ADDR   = 8'ha0;

  // Field positions in the photodiode selection register
  localparam int          PAIR_GAIN_COMP_BIT = 5;
  localparam int          SLEEP_AFTER_IRQ_BIT = 4;
  localparam int          MASK_UP_BIT        = 3;
  localparam int          MASK_DOWN_BIT      = 2;
  localparam int          MASK_LEFT_BIT      = 1;
  localparam int          MASK_RIGHT_BIT     = 0;
  localparam logic [7:0]  PD_SELECT_WMASK    = 8'h3f;

  // Sign and magnitude layout of the offset
  localparam int          OFFSET_SIGN_BIT    = 7;

  // Reset values
  localparam logic [7:0]  DL_OFFSET_RST      = 8'h00;
  localparam logic [7:0]  PD_SELECT_RST      = 8'h00;
  localparam logic [7:0]  GEST_ENTRY_RST     = 8'h00;
  localparam logic [7:0]  PROX_RESULT_RST    = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ      = 8'h00;

  // Pair arithmetic limits
  localparam logic [9:0]  PAIR_MAX           = 10'h1fe;
  localparam logic [7:0]  RESULT_MAX         = 8'hff;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ppge_reg_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] up;
    logic [DATA_W-1:0] down;
    logic [DATA_W-1:0] left;
    logic [DATA_W-1:0] right;
    logic              valid;
  } ppge_diodes_s;

  typedef enum logic [0:0] {
    PPGE_ACTIVE,
    PPGE_LOW_POWER
  } ppge_sleep_e;

endpackage : ppge_pkg

// *** tb/ppge_core_asserts.sv ***
/*
  Port checker for ppge_core.
  Assumes binding to ppge_core, all ports on ref_clk.
*/
`timescale 1ns/100ps
module ppge_core_chk
  import ppge_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire ppge_reg_req_s     reg_req,
  input wire logic [DATA_W-1:0] rd_data_r,
  input wire ppge_diodes_s      diodes,
  input wire logic              irq_asserted,
  input wire logic              sleep_decision,
  input wire logic              irq_clear,
  input wire logic [7:0]        proximity_result_r,
  input wire logic              result_valid_r,
  input wire logic              gesture_start_r,
  input wire logic              low_power_r
);
  logic [7:0] sel_r;
  logic [7:0] thr_r;
  logic       unmapped;
  assign unmapped = !(reg_req.addr inside {PROX_RESULT_ADDR, DL_OFFSET_ADDR, PD_SELECT_ADDR, GEST_ENTRY_ADDR});
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) sel_r <= 8'h00;
    else if (reg_req.wr && reg_req.addr == PD_SELECT_ADDR) sel_r <= reg_req.wdata;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) thr_r <= 8'h00;
    else if (reg_req.wr && reg_req.addr == GEST_ENTRY_ADDR) thr_r <= reg_req.wdata;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_valid_follows: assert property (diodes.valid |=> result_valid_r)
    else $error("result_valid_r missing after sample");
  a_no_spurious_flags: assert property (!diodes.valid |=> !result_valid_r && !gesture_start_r)
    else $error("flag without sample");
  a_result_holds: assert property (!diodes.valid |=> $stable(proximity_result_r))
    else $error("result changed without sample");
  a_entry_compare: assert property (result_valid_r |-> gesture_start_r == (proximity_result_r >= $past(thr_r)))
    else $error("gesture start disagrees with threshold");
  a_sleep_entry: assert property (sel_r[SLEEP_AFTER_IRQ_BIT] && irq_asserted && sleep_decision && !irq_clear |=> low_power_r)
    else $error("low power not entered");
  a_sleep_cause: assert property ($rose(low_power_r) |-> $past(sel_r[SLEEP_AFTER_IRQ_BIT] && irq_asserted && sleep_decision))
    else $error("low power entered without cause");
  a_sleep_exit: assert property (low_power_r && irq_clear |=> !low_power_r)
    else $error("low power not left on clear");
  a_sleep_holds: assert property (low_power_r && !irq_clear |=> low_power_r)
    else $error("low power left without clear");
  a_unmapped_zero: assert property (reg_req.rd && unmapped |=> rd_data_r == UNMAPPED_READ)
    else $error("unmapped read not zero");
  a_rd_holds: assert property (!reg_req.rd |=> $stable(rd_data_r))
    else $error("read data changed without read");
endmodule : ppge_core_chk
bind ppge_core ppge_core_chk u_chk (.*);

// *** tb/ppge_host_model.sv ***
/*
  Host model: register writes, reads and interrupt clear.
  Assumes ppge_core register port on ref_clk.
*/
`timescale 1ns/100ps
module ppge_host_model
  import ppge_pkg::*;
(
  input wire logic              ref_clk,
  output ppge_reg_req_s         reg_req,
  output logic                  irq_clear,
  input wire logic [DATA_W-1:0] rd_data_r
);
  initial begin
    reg_req   = '0;
    irq_clear = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 reg_req.addr = a;
    reg_req.wdata = (a == PD_SELECT_ADDR) ? (d & 8'h3f) : d;
    reg_req.wr = 1'b1;
    @(posedge ref_clk);
    #1 reg_req.wr = 1'b0;
    reg_req.addr = ~a;
    reg_req.wdata = ~reg_req.wdata;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1 reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(posedge ref_clk);
    #1 reg_req.rd = 1'b0;
    reg_req.addr = ~a;
    d = rd_data_r;
  endtask : rd
  task automatic clr;
    @(posedge ref_clk);
    #1 irq_clear = 1'b1;
    @(posedge ref_clk);
    #1 irq_clear = 1'b0;
  endtask : clr
endmodule : ppge_host_model

// *** tb/tb.sv ***
/*
  Testbench for ppge_core: register, sample and sleep sequences.
  Assumes a 50 MHz ref_clk and the host model on the register port.
*/
`timescale 1ns/100ps
module tb;
  import ppge_pkg::*;
  logic          ref_clk = 1'b0;
  logic          reset_n = 1'b0;
  ppge_reg_req_s reg_req;
  logic [7:0]    rd_data_r, res, v;
  ppge_diodes_s  diodes = '0;
  logic          irq_asserted = 1'b0, sleep_decision = 1'b0, irq_clear, valid_r, start_r, low_power_r;
  int            error_cnt = 0, samples_checked = 0;
  logic [7:0]    mval [4] = '{8'h08, 8'h10, 8'h20, 8'h40};
  always #10 ref_clk = ~ref_clk;
  ppge_core dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_req(reg_req), .rd_data_r(rd_data_r),
    .diodes(diodes), .irq_asserted(irq_asserted), .sleep_decision(sleep_decision), .irq_clear(irq_clear),
    .proximity_result_r(res), .result_valid_r(valid_r), .gesture_start_r(start_r), .low_power_r(low_power_r));
  ppge_host_model host (.ref_clk(ref_clk), .reg_req(reg_req), .irq_clear(irq_clear), .rd_data_r(rd_data_r));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic smp(input logic [31:0] udlr, input logic [7:0] e, input logic s);
    @(posedge ref_clk);
    #1 {diodes.up, diodes.down, diodes.left, diodes.right} = udlr;
    diodes.valid = 1'b1;
    @(posedge ref_clk);
    #1 {diodes.up, diodes.down, diodes.left, diodes.right} = ~udlr;
    diodes.valid = 1'b0;
    chk("result", e, res);
    chk("valid", 8'h01, {7'h0, valid_r});
    chk("start", {7'h0, s}, {7'h0, start_r});
  endtask : smp
  task automatic rb(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk("readback", e, v);
  endtask : rb
  task automatic dec;
    @(posedge ref_clk);
    #1 sleep_decision = 1'b1;
    @(posedge ref_clk);
    #1 sleep_decision = 1'b0;
  endtask : dec
  initial begin #200000 error_cnt++; summarize(); end
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    rb(8'h9e, 8'h00); rb(8'h9f, 8'h00); rb(8'ha0, 8'h00); rb(8'h9c, 8'h00);
    rb(8'h55, 8'h00);
    host.wr(8'h9e, 8'h85); host.wr(8'h9f, 8'h3f); host.wr(8'ha0, 8'h5a); host.wr(8'h9c, 8'h77);
    rb(8'h9e, 8'h85); rb(8'h9f, 8'h3f); rb(8'ha0, 8'h5a); rb(8'h9c, 8'h00);
    host.wr(8'h9e, 8'h00); host.wr(8'h9f, 8'h00); host.wr(8'ha0, 8'h1e);
    smp(32'h40201008, 8'h1e, 1'b1);
    host.wr(8'ha0, 8'h1f);
    smp(32'h40201008, 8'h1e, 1'b0);
    rb(8'h9c, 8'h1e);
    host.wr(8'h9e, 8'h85);
    smp(32'h40201008, 8'h1f, 1'b1);
    host.wr(8'h9e, 8'h05);
    smp(32'h40201008, 8'h1c, 1'b0);
    host.wr(8'h9e, 8'hff);
    smp(32'h40201008, 8'h3d, 1'b1);
    host.wr(8'h9e, 8'h00);
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h9f, 8'h01 << i);
      smp(32'h40201008, (8'd120 - mval[i]) >> 2, 1'b0);
    end
    host.wr(8'h9f, 8'h2e);
    smp(32'h000000ff, 8'h7f, 1'b1);
    host.wr(8'h9f, 8'h00);
    smp(32'h000000ff, 8'h3f, 1'b1);
    host.wr(8'h9e, 8'hff);
    host.wr(8'h9f, 8'h25);
    smp(32'hffffffff, 8'hff, 1'b1);
    irq_asserted = 1'b1;
    dec();
    chk("low_power", 8'h00, {7'h0, low_power_r});
    host.wr(8'h9f, 8'h10);
    dec();
    chk("low_power", 8'h01, {7'h0, low_power_r});
    repeat (3) @(posedge ref_clk);
    chk("low_power", 8'h01, {7'h0, low_power_r});
    host.clr();
    irq_asserted = 1'b0;
    chk("low_power", 8'h00, {7'h0, low_power_r});
    summarize();
  end
endmodule : tb
